// >>> tb/sdram_fetch_read_burst_asserts.sv
// Port checker for the fetch read-burst sequencer
`default_nettype none
module sdram_fetch_read_burst_asserts (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic fetch_valid_in,
   input wire logic icache_hit_in,
   input wire logic fetch_ready_out,
   input wire logic hit_ack_out,
   input wire logic word_valid_out,
   input wire logic word_last_out,
   input wire logic done_out,
   input wire logic sd_clk_in,
   input wire fetch_burst_pkg::sdram_cmd_s sd_cmd_out
);
   logic ras;
   logic cas;
   logic we;
   logic [3:0] since_we_r;
   assign ras = !sd_cmd_out.ras_n;
   assign cas = !sd_cmd_out.cas_n;
   assign we = !sd_cmd_out.we_n;
   // Saturates so an idle link never wraps into a false gap
   always_ff @(posedge sd_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         since_we_r <= 4'hf;
      end else if (we) begin
         since_we_r <= 4'h1;
      end else if (since_we_r != 4'hf) begin
         since_we_r <= since_we_r + 4'h1;
      end
   end
   chk_ras_to_cas:
      assert property (@(posedge sd_clk_in) disable iff (!reset_n_in)
         ras |-> ##3 cas) else $error("column strobe late after row");
   chk_cas_needs_ras:
      assert property (@(posedge sd_clk_in) disable iff (!reset_n_in)
         cas |-> $past(ras, 3)) else $error("column without row");
   chk_term_time:
      assert property (@(posedge sd_clk_in) disable iff (!reset_n_in)
         cas |-> (##2 we) or (##8 we)) else $error("terminate misplaced");
   chk_term_cause:
      assert property (@(posedge sd_clk_in) disable iff (!reset_n_in)
         we |-> $past(cas, 2) || $past(cas, 8)) else $error("stray stop");
   chk_one_strobe:
      assert property (@(posedge sd_clk_in) disable iff (!reset_n_in)
         $onehot0({ras, cas, we})) else $error("two strobes at once");
   chk_cas_gap:
      assert property (@(posedge sd_clk_in) disable iff (!reset_n_in)
         cas |-> since_we_r >= 4'h7) else $error("column command too soon");
   chk_hit_ack:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         ce_in && fetch_valid_in && fetch_ready_out && icache_hit_in
         |=> hit_ack_out && !word_valid_out) else $error("hit not answered");
   chk_done_last:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         done_out |-> word_valid_out && word_last_out && fetch_ready_out)
         else $error("done without last word");
   chk_busy_words:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         word_valid_out && !word_last_out |-> !fetch_ready_out)
         else $error("ready before last word");
   chk_pair_words:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         word_last_out |-> $past(word_valid_out)) else $error("single word");
   cov_uncached: cover property (@(posedge sd_clk_in) cas ##2 we);
   cov_line_fill: cover property (@(posedge sd_clk_in) cas ##8 we);
   cov_hit: cover property (@(posedge clk_sys_in) hit_ack_out);
endmodule
bind sdram_fetch_read_burst sdram_fetch_read_burst_asserts chk_u (
   .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
   .fetch_valid_in(fetch_valid_in), .icache_hit_in(icache_hit_in),
   .fetch_ready_out(fetch_ready_out), .hit_ack_out(hit_ack_out),
   .word_valid_out(word_valid_out), .word_last_out(word_last_out),
   .done_out(done_out), .sd_clk_in(sd_clk_in), .sd_cmd_out(sd_cmd_out)
);
`default_nettype wire

// >>> tb/sdram_read_model.sv
// Behavioural SDRAM read model with column latency two
`default_nettype none
module sdram_read_model (
   input wire logic sd_clk_in,
   input wire fetch_burst_pkg::sdram_cmd_s sd_cmd_in,
   output logic [15:0] sd_dq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] bank;
   logic [4:0] row;
   logic [8:0] col;
   logic [15:0] k;
   logic [15:0] last = 16'h0000;
   logic go = 1'b0;
   logic stop = 1'b0;
   logic run = 1'b0;
   int ras_count = 0;
   initial sd_dq_out = 16'h0000;
   always @(posedge sd_clk_in) begin
      if (go) begin
         run = 1'b1;
         k = 16'h0000;
      end else if (run) begin
         k = k + 16'h0001;
      end
      // Terminate takes effect two cycles after the command
      if (stop) run = 1'b0;
      go = !sd_cmd_in.cas_n;
      stop = !sd_cmd_in.we_n;
      if (!sd_cmd_in.ras_n) begin
         bank = sd_cmd_in.bank;
         row = sd_cmd_in.addr[4:0];
         ras_count++;
      end
      if (!sd_cmd_in.cas_n) col = sd_cmd_in.addr[8:0];
      // Released bus toggles so a stale word never passes
      last = run ? {bank, row, col} + k : ~last;
      sd_dq_out <= last;
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the fetch read-burst sequencer
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   mismatches++; \
   $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0;
   logic sd_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic fetch_valid_in = 1'b0;
   logic icache_hit_in = 1'b0;
   logic mmu_en_in = 1'b0;
   logic ce_in = 1'b1;
   logic fetch_ready_out, hit_ack_out, word_valid_out;
   logic word_last_out, done_out;
   logic [15:0] word_out;
   logic [15:0] sd_dq;
   logic [19:0] note;
   logic [19:0] notes[$];
   fetch_burst_pkg::fetch_req_s fetch_req_in = '0;
   fetch_burst_pkg::sdram_cmd_s sd_cmd;
   int mismatches = 0;
   int samples_checked = 0;
   int lat, lat_off, ras_seen;
   initial forever #20 clk_sys_in = ~clk_sys_in;
   // Link clock offset so the two domains never line up
   initial begin
      #7;
      forever #16 sd_clk_in = ~sd_clk_in;
   end
   sdram_fetch_read_burst dut_u (.clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in), .ce_in(ce_in), .fetch_valid_in(fetch_valid_in),
      .fetch_req_in(fetch_req_in), .icache_hit_in(icache_hit_in),
      .mmu_en_in(mmu_en_in), .fetch_ready_out(fetch_ready_out),
      .hit_ack_out(hit_ack_out), .word_valid_out(word_valid_out),
      .word_out(word_out), .word_last_out(word_last_out),
      .done_out(done_out), .sd_clk_in(sd_clk_in), .sd_dq_in(sd_dq),
      .sd_cmd_out(sd_cmd));
   sdram_read_model mem_u (.sd_clk_in(sd_clk_in), .sd_cmd_in(sd_cmd),
      .sd_dq_out(sd_dq));
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Notes the expected answer, then returns the take-to-answer latency
   task automatic fetch(input logic [23:0] a, input logic lf, input logic h);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (fetch_ready_out !== 1'b1 && n < 500);
      @(posedge clk_sys_in);
      fetch_valid_in <= 1'b1;
      fetch_req_in <= '{a, lf};
      icache_hit_in <= h;
      if (h) notes.push_back(20'h80000);
      else for (int i = 0; i < (lf ? 8 : 2); i++)
         notes.push_back({2'b01, {2{i == (lf ? 7 : 1)}},
            {a[23:22], a[13:9], a[8:0]} + 16'(i)});
      @(posedge clk_sys_in);
      fetch_valid_in <= 1'b0;
      lat = 1;
      while (hit_ack_out !== 1'b1 && word_valid_out !== 1'b1 && lat < 400)
      begin
         @(negedge clk_sys_in);
         lat++;
      end
      `CHK(n < 500 && lat < 400, 1'b1)
   endtask
   always @(negedge clk_sys_in) begin
      if (hit_ack_out === 1'b1 || word_valid_out === 1'b1) begin
         note = notes.size() > 0 ? notes.pop_front() : 20'hfffff;
         `CHK({hit_ack_out, word_valid_out, word_last_out, done_out}, note[19:16])
         if (!note[19]) `CHK(word_out, note[15:0])
      end
   end
   initial begin
      #400000;
      mismatches++;
      end_sim;
   end
   initial begin
      void'($urandom(33));
      repeat (4) @(posedge clk_sys_in);
      `CHK({fetch_ready_out, sd_cmd}, {1'b0, fetch_burst_pkg::CMD_NOP})
      reset_n_in <= 1'b1;
      $display("test reset done");
      repeat (16) fetch(24'($urandom), 1'($urandom), $urandom % 4 == 0);
      $display("test random bursts done");
      ras_seen = mem_u.ras_count;
      repeat (5) fetch(24'($urandom), 1'b1, 1'b1);
      // Frozen block must ignore a request held at its port
      @(posedge clk_sys_in);
      ce_in <= 1'b0;
      fetch_valid_in <= 1'b1;
      icache_hit_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      `CHK(hit_ack_out, 1'b0)
      fetch_valid_in <= 1'b0;
      ce_in <= 1'b1;
      repeat (30) @(negedge clk_sys_in);
      `CHK(mem_u.ras_count, ras_seen)
      $display("test cache hits done");
      fetch(24'h000100, 1'b0, 1'b0);
      lat_off = lat;
      @(posedge clk_sys_in);
      mmu_en_in <= 1'b1;
      fetch(24'h380100, 1'b0, 1'b0);
      `CHK(lat > lat_off + 12, 1'b1)
      fetch(24'h380200, 1'b0, 1'b0);
      `CHK(lat < lat_off + 4, 1'b1)
      // Four new sections push the first one out
      for (int s = 8; s < 12; s++) fetch({5'(s), 19'h00040}, 1'b0, 1'b0);
      fetch(24'h380300, 1'b0, 1'b0);
      `CHK(lat > lat_off + 12, 1'b1)
      repeat (40) @(negedge clk_sys_in);
      `CHK(notes.size(), 0)
      $display("test translation done");
      end_sim;
   end
endmodule
`default_nettype wire

// >>> verilog/fetch_burst_pkg.sv
// Constants, types and timing for the fetch read-burst sequencer
`default_nettype none
package fetch_burst_pkg;
   localparam int ADDR_W = 24;
   localparam int WORD_W = 16;
   localparam int ROW_W = 13;
   localparam int COL_W = 9;
   localparam int BANK_W = 2;
   localparam int MAX_WORDS = 8;
   localparam int IDX_W = 3;
   localparam int CNT_W = 4;
   localparam int TLB_ENTRIES = 4;
   localparam int SECT_LSB = 19;
   localparam int SECT_W = ADDR_W - SECT_LSB;
   localparam int COL_LSB = 0;
   localparam int ROW_LSB = COL_W;
   localparam int BANK_LSB = COL_W + ROW_W;
   // Link cycle counts; one link cycle is two processor cycles
   localparam logic [CNT_W-1:0] RCD_TC = 4'h3;
   localparam logic [CNT_W-1:0] CAS_LAT_TC = 4'h2;
   localparam logic [CNT_W-1:0] TERM_UNCACHED_TC = 4'h2;
   localparam logic [CNT_W-1:0] TERM_LINE_TC = 4'h8;
   localparam logic [CNT_W-1:0] GAP_TC = 4'h5;
   localparam int CPU_PER_TC = 2;
   // Table walk time in system clock cycles
   localparam logic [7:0] WALK_CYCLES = 8'h10;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic line_fill;
   } fetch_req_s;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0] addr;
   } sdram_cmd_s;

   localparam sdram_cmd_s CMD_NOP = '{1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
endpackage
`default_nettype wire

// >>> verilog/sdram_fetch_read_burst.sv
// Fetch read-burst sequencer facing external SDRAM
`default_nettype none
module sdram_fetch_read_burst (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic fetch_valid_in,
   input wire fetch_burst_pkg::fetch_req_s fetch_req_in,
   input wire logic icache_hit_in,
   input wire logic mmu_en_in,
   output logic fetch_ready_out,
   output logic hit_ack_out,
   output logic word_valid_out,
   output logic [fetch_burst_pkg::WORD_W-1:0] word_out,
   output logic word_last_out,
   output logic done_out,
   input wire logic sd_clk_in,
   input wire logic [fetch_burst_pkg::WORD_W-1:0] sd_dq_in,
   output fetch_burst_pkg::sdram_cmd_s sd_cmd_out
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_WALK = 4'h2,
      S_LINK = 4'h4,
      S_SEND = 4'h8
   } sys_state_e;

   typedef enum logic [4:0] {
      L_IDLE = 5'h01,
      L_ACT = 5'h02,
      L_RCD = 5'h04,
      L_BURST = 5'h08,
      L_GAP = 5'h10
   } link_state_e;

   // System-domain reset and state
   logic rst_meta_r, rst_n_r;
   sys_state_e sys_r;
   fetch_burst_pkg::fetch_req_s req_r;
   logic req_tgl_r;
   logic [7:0] walk_cnt_r;
   logic [fetch_burst_pkg::IDX_W-1:0] out_idx_r;
   logic done_meta_r, done_sync_r, done_seen_r;
   logic tlb_hit, tlb_fill, link_done;
   logic [fetch_burst_pkg::SECT_W-1:0] look_sect;
   logic [fetch_burst_pkg::IDX_W-1:0] last_idx;

   // Link-domain state
   logic lrst_meta_r, lrst_n_r;
   logic lce_meta_r, lce_r;
   logic req_meta_r, req_sync_r, req_seen_r;
   logic pend_r;
   link_state_e link_r;
   logic [fetch_burst_pkg::CNT_W-1:0] cnt_r;
   logic [fetch_burst_pkg::CNT_W-1:0] since_r;
   logic [fetch_burst_pkg::WORD_W-1:0] dq_r;
   logic [fetch_burst_pkg::WORD_W-1:0] buf_r [fetch_burst_pkg::MAX_WORDS];
   logic done_tgl_r;
   logic [fetch_burst_pkg::CNT_W-1:0] term_at, last_at, latch_idx;
   logic latch_now, req_edge;

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   section_tlb u_tlb (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .ce_in(ce_in),
      .look_sect_in(look_sect),
      .fill_in(tlb_fill),
      .hit_out(tlb_hit)
   );

   // Refill uses the held request; the input may move during a walk
   assign look_sect = (sys_r == S_WALK) ?
      req_r.addr[fetch_burst_pkg::ADDR_W-1:fetch_burst_pkg::SECT_LSB] :
      fetch_req_in.addr[fetch_burst_pkg::ADDR_W-1:fetch_burst_pkg::SECT_LSB];
   // Walk fills the buffer once the table fetch has finished
   assign tlb_fill = (sys_r == S_WALK) && (walk_cnt_r == 8'h01);
   assign link_done = done_sync_r ^ done_seen_r;
   assign last_idx = req_r.line_fill ?
      fetch_burst_pkg::IDX_W'(fetch_burst_pkg::TERM_LINE_TC - 4'h1) :
      fetch_burst_pkg::IDX_W'(fetch_burst_pkg::TERM_UNCACHED_TC - 4'h1);

   // Done toggle from the link side
   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         done_meta_r <= 1'b0;
         done_sync_r <= 1'b0;
         done_seen_r <= 1'b0;
      end else if (ce_in) begin
         done_meta_r <= done_tgl_r;
         done_sync_r <= done_meta_r;
         done_seen_r <= done_sync_r;
      end
   end

   // Request flow; the request is held stable while the link works
   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sys_r <= S_IDLE;
         req_r <= '0;
         req_tgl_r <= 1'b0;
         walk_cnt_r <= 8'h00;
         out_idx_r <= '0;
         fetch_ready_out <= 1'b0;
         hit_ack_out <= 1'b0;
      end else if (ce_in) begin
         hit_ack_out <= 1'b0;
         case (sys_r)
            S_IDLE: begin
               fetch_ready_out <= 1'b1;
               if (fetch_valid_in && fetch_ready_out) begin
                  req_r <= fetch_req_in;
                  if (icache_hit_in) begin
                     hit_ack_out <= 1'b1;
                  end else if (mmu_en_in && !tlb_hit) begin
                     fetch_ready_out <= 1'b0;
                     walk_cnt_r <= fetch_burst_pkg::WALK_CYCLES;
                     sys_r <= S_WALK;
                  end else begin
                     fetch_ready_out <= 1'b0;
                     req_tgl_r <= ~req_tgl_r;
                     sys_r <= S_LINK;
                  end
               end
            end
            S_WALK: begin
               walk_cnt_r <= walk_cnt_r - 8'h01;
               if (walk_cnt_r == 8'h01) begin
                  req_tgl_r <= ~req_tgl_r;
                  sys_r <= S_LINK;
               end
            end
            S_LINK: begin
               if (link_done) begin
                  out_idx_r <= '0;
                  sys_r <= S_SEND;
               end
            end
            S_SEND: begin
               out_idx_r <= out_idx_r + 3'h1;
               if (out_idx_r == last_idx) begin
                  fetch_ready_out <= 1'b1;
                  sys_r <= S_IDLE;
               end
            end
            default: begin
               sys_r <= S_IDLE;
            end
         endcase
      end
   end

   // Buffer is quiet here: the link finished before the toggle arrived
   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         word_valid_out <= 1'b0;
         word_out <= '0;
         word_last_out <= 1'b0;
         done_out <= 1'b0;
      end else if (ce_in) begin
         word_valid_out <= (sys_r == S_SEND);
         word_out <= buf_r[out_idx_r];
         word_last_out <= (sys_r == S_SEND) && (out_idx_r == last_idx);
         done_out <= (sys_r == S_SEND) && (out_idx_r == last_idx);
      end
   end

   // Link-domain reset, enable and request crossing
   always_ff @(posedge sd_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lrst_meta_r <= 1'b0;
         lrst_n_r <= 1'b0;
      end else begin
         lrst_meta_r <= 1'b1;
         lrst_n_r <= lrst_meta_r;
      end
   end

   always_ff @(posedge sd_clk_in or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         lce_meta_r <= 1'b0;
         lce_r <= 1'b0;
      end else begin
         lce_meta_r <= ce_in;
         lce_r <= lce_meta_r;
      end
   end

   always_ff @(posedge sd_clk_in or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         req_meta_r <= 1'b0;
         req_sync_r <= 1'b0;
         req_seen_r <= 1'b0;
      end else if (lce_r) begin
         req_meta_r <= req_tgl_r;
         req_sync_r <= req_meta_r;
         req_seen_r <= req_sync_r;
      end
   end

   assign req_edge = req_sync_r ^ req_seen_r;
   // All spacing below counts link (traffic-controller) cycles
   assign term_at = req_r.line_fill ? fetch_burst_pkg::TERM_LINE_TC :
      fetch_burst_pkg::TERM_UNCACHED_TC;
   assign last_at = fetch_burst_pkg::CAS_LAT_TC + term_at;
   assign latch_idx = since_r - fetch_burst_pkg::CAS_LAT_TC - 4'h1;
   assign latch_now = (link_r == L_BURST) &&
      (since_r > fetch_burst_pkg::CAS_LAT_TC) && (since_r <= last_at);

   // Input capture; a word on the bus is taken one cycle later
   always_ff @(posedge sd_clk_in or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         dq_r <= '0;
      end else if (lce_r) begin
         dq_r <= sd_dq_in;
      end
   end

   generate
      for (genvar w = 0; w < fetch_burst_pkg::MAX_WORDS; w++) begin : g_buf
         always_ff @(posedge sd_clk_in or negedge lrst_n_r) begin
            if (!lrst_n_r) begin
               buf_r[w] <= '0;
            end else if (lce_r && latch_now &&
                         latch_idx == fetch_burst_pkg::CNT_W'(w)) begin
               buf_r[w] <= dq_r;
            end
         end
      end
   endgenerate

   always_ff @(posedge sd_clk_in or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         pend_r <= 1'b0;
      end else if (lce_r) begin
         if (req_edge) begin
            pend_r <= 1'b1;
         end else if (link_r == L_ACT) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Command sequencer; the command register holds this cycle's command
   always_ff @(posedge sd_clk_in or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         link_r <= L_IDLE;
         cnt_r <= '0;
         since_r <= '0;
         done_tgl_r <= 1'b0;
         sd_cmd_out <= fetch_burst_pkg::CMD_NOP;
      end else if (lce_r) begin
         sd_cmd_out <= fetch_burst_pkg::CMD_NOP;
         case (link_r)
            L_IDLE: begin
               if (pend_r) begin
                  link_r <= L_ACT;
                  sd_cmd_out.ras_n <= 1'b0;
                  sd_cmd_out.bank <= req_r.addr[fetch_burst_pkg::BANK_LSB +:
                                                fetch_burst_pkg::BANK_W];
                  sd_cmd_out.addr <= req_r.addr[fetch_burst_pkg::ROW_LSB +:
                                                fetch_burst_pkg::ROW_W];
               end
            end
            L_ACT: begin
               cnt_r <= fetch_burst_pkg::RCD_TC - 4'h2;
               link_r <= L_RCD;
            end
            L_RCD: begin
               if (cnt_r == '0) begin
                  link_r <= L_BURST;
                  since_r <= '0;
                  sd_cmd_out.cas_n <= 1'b0;
                  sd_cmd_out.bank <= req_r.addr[fetch_burst_pkg::BANK_LSB +:
                                                fetch_burst_pkg::BANK_W];
                  sd_cmd_out.addr <= {{(fetch_burst_pkg::ROW_W -
                                        fetch_burst_pkg::COL_W){1'b0}},
                     req_r.addr[fetch_burst_pkg::COL_LSB +:
                                fetch_burst_pkg::COL_W]};
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            L_BURST: begin
               since_r <= since_r + 4'h1;
               if (since_r + 4'h1 == term_at) begin
                  sd_cmd_out.we_n <= 1'b0;
               end
               if (since_r == last_at) begin
                  done_tgl_r <= ~done_tgl_r;
                  cnt_r <= fetch_burst_pkg::GAP_TC -
                     fetch_burst_pkg::RCD_TC - 4'h2;
                  link_r <= L_GAP;
               end
            end
            L_GAP: begin
               // Row strobe may go out early so the column lands on time
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (pend_r) begin
                  link_r <= L_ACT;
                  sd_cmd_out.ras_n <= 1'b0;
                  sd_cmd_out.bank <= req_r.addr[fetch_burst_pkg::BANK_LSB +:
                                                fetch_burst_pkg::BANK_W];
                  sd_cmd_out.addr <= req_r.addr[fetch_burst_pkg::ROW_LSB +:
                                                fetch_burst_pkg::ROW_W];
               end else begin
                  link_r <= L_IDLE;
               end
            end
            default: begin
               link_r <= L_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> verilog/section_tlb.sv
// Lookaside buffer of recently used memory sections
`default_nettype none
module section_tlb (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [fetch_burst_pkg::SECT_W-1:0] look_sect_in,
   input wire logic fill_in,
   output logic hit_out
);
   logic [fetch_burst_pkg::SECT_W-1:0] tag_r [fetch_burst_pkg::TLB_ENTRIES];
   logic [fetch_burst_pkg::TLB_ENTRIES-1:0] valid_r;
   logic [fetch_burst_pkg::TLB_ENTRIES-1:0] match;
   logic [1:0] victim_r;

   genvar g;
   generate
      for (g = 0; g < fetch_burst_pkg::TLB_ENTRIES; g++) begin : g_ent
         assign match[g] = valid_r[g] && (tag_r[g] == look_sect_in);
         // Round-robin refill keeps the most recent sections
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               valid_r[g] <= 1'b0;
               tag_r[g] <= '0;
            end else if (ce_in && fill_in && victim_r == 2'(g)) begin
               valid_r[g] <= 1'b1;
               tag_r[g] <= look_sect_in;
            end
         end
      end
   endgenerate

   assign hit_out = |match;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         victim_r <= 2'h0;
      end else if (ce_in && fill_in) begin
         victim_r <= victim_r + 2'h1;
      end
   end
endmodule
`default_nettype wire
